/* File: src/dir_pointer_entry_loader.sv */
// Contract
// R01: Extended mode is on only with paging and extension set, long mode clear.
// R02: 32-bit linear addresses map to physical addresses up to 52 bits.
// R03: Four hidden entry registers, filled from memory at the table base.
// R04: Each entry register roots its own translation hierarchy.
// R05: Table base is base register bits 31:5; other bits ignored.
// R06: Table holds four 64-bit entries, each governing one 1-GByte region.
// R07: Reload on mode write that keeps mode on and changes a listed bit.
// R08: Base write while mode on reloads from the newly written address.
// R09: Task switch changing the base while mode on reloads from new base.
// R10: Virtualization transitions may load the entry registers directly.
// R11: Entries are fetched write-back unless caching is disabled.
// R12: Bit 0 is the valid flag; must be 1 to reference a directory.
// R13: Bit 3 is write-through, bit 4 cache-disable for the directory access.
// R14: Bits M-1:12 give the directory base; bits 11:9 ignored.
// R15: Bits 2:1, 8:5 and 63:M are reserved, must be zero.
// R16: Valid entry with reserved bit raises protection fault code 0, no load.
// R17: Reserved check on invalid entries is an option, documented.
// R18: Physical address bits 51:M are forced to zero.
// R19: Physical width parameter never exceeds 52.
// R20: Uncached fetch is an optional model-specific alternative.
// R21: Linear bits 31:30 pick the entry; invalid entry gives page fault.
// R22: Translation uses only the entry registers, never the base or memory.
// R23: Four 8-byte reads at 0, 8, 16, 24; all checked before commit.
`timescale 1ns/10ps
module dir_pointer_entry_loader
   import dpe_pkg::*;
#(
   parameter int MAX_PA = PA_W,     // max_phys_addr_width
   parameter bit CHK_NP = 1'b0,     // also check invalid entries
   parameter bit UC_FETCH = 1'b0    // fetch entries uncached
) (
   input wire logic clk,                          // core clock
   input wire logic arst_n,                       // async reset
   input wire logic lme,                          // long_mode_enable
   input wire logic mode_wr,                      // control reg write
   input wire mode_ctl_t mode_wdata,              // new control bits
   input wire logic base_wr,                      // base reg write
   input wire logic task_sw,                      // task switch load
   input wire logic [63:0] base_wdata,            // new base value
   input wire logic virt_ld,                      // virtualization load
   input wire logic [N_ENT-1:0][63:0] virt_ent,   // entries to load
   output logic mem_req_v,                        // read request
   output mem_req_t mem_req,                      // address, attr
   input wire logic mem_req_rdy,                  // request taken
   input wire logic mem_rsp_v,                    // read data valid
   input wire logic [63:0] mem_rsp_data,          // read data
   output logic ext_mode,                         // mode active
   output logic [63:0] translation_table_base,    // base reg
   output mode_ctl_t ctl_out,                     // control bits
   output logic busy,                             // fetch running
   output logic load_done,                        // entries committed
   output logic gp_fault,                         // protection fault
   output logic [15:0] gp_err_code,               // fault code
   input wire logic xl_req,                       // lookup request
   input wire logic [LIN_W-1:0] xl_lin,           // linear address
   output logic xl_ack,                           // lookup answer
   output xl_ans_t xl_ans                         // lookup result
);

   // Width check
   if (MAX_PA > PA_W || MAX_PA < LIN_W) begin : g_chk // R19
      $error("MAX_PA must lie in 32..52");
   end

   ////////////////////////////////////////////////////////////////
   // State
   mode_ctl_t ctl_r;
   logic [63:0] base_r;
   logic [N_ENT-1:0][63:0] ent_r;
   logic [N_ENT-1:0][63:0] stg_r;
   st_t st_r;
   logic [1:0] idx_r;
   logic [BASE_HI-BASE_LO:0] fbase_r;
   logic [BASE_HI-BASE_LO:0] pbase_r;
   logic pend_r;
   logic bad_r;
   logic done_r;
   logic gp_r;
   logic ack_r;
   xl_ans_t ans_r;

   ////////////////////////////////////////////////////////////////
   // Reload triggers
   wire mode_on = ctl_r.pg & ctl_r.pae & ~lme; // R01
   wire new_on = mode_wdata.pg & mode_wdata.pae & ~lme; // R01
   wire ctl_chg = mode_wdata != ctl_r;
   wire trg_mode = mode_wr & new_on & ctl_chg; // R07
   wire trg_base = base_wr & mode_on; // R08
   wire trg_ts = task_sw & mode_on & (base_wdata != base_r); // R09
   wire trg_any = trg_mode | trg_base | trg_ts;
   wire base_in = base_wr | task_sw;
   // Only bits 31:5 locate the table
   wire [BASE_HI-BASE_LO:0] trg_addr = base_in ? base_wdata[BASE_HI:BASE_LO]
                                              : base_r[BASE_HI:BASE_LO]; // R05

   ////////////////////////////////////////////////////////////////
   // Entry checking
   localparam logic [63:0] RSV_MASK = RSV_LO_MASK | ({64{1'b1}} << MAX_PA); // R15
   // Reserved bits only matter on valid entries unless CHK_NP
   wire rsp_bad = (mem_rsp_data[P_BIT] | CHK_NP) & (|(mem_rsp_data & RSV_MASK)); // R16 R17
   wire rsp_take = (st_r == ST_WAIT) & mem_rsp_v;
   wire rsp_last = rsp_take & (idx_r == LAST_IDX);
   wire seq_bad = bad_r | rsp_bad;
   wire commit = rsp_last & ~pend_r & ~seq_bad; // R23
   wire fault = rsp_last & ~pend_r & seq_bad; // R16

   ////////////////////////////////////////////////////////////////
   // Fetch request
   assign mem_req_v = (st_r == ST_REQ);
   // Consecutive 8-byte reads from the 32-byte table
   assign mem_req.addr = {{(PA_W-LIN_W){1'b0}}, fbase_r, idx_r, 3'h0}; // R06 R23
   assign mem_req.attr = (ctl_r.cd | UC_FETCH) ? ATTR_UC : ATTR_WB; // R11 R20

   ////////////////////////////////////////////////////////////////
   // Control and base registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_r <= '0;
         base_r <= 64'h0000_0000_0000_0000;
      end else begin
         if (mode_wr) begin
            ctl_r <= mode_wdata;
         end
         if (base_in) begin
            base_r <= base_wdata;
         end
      end
   end

   // Fetch sequencer; a trigger during an outstanding read is parked
   // so the stale response is never mistaken for a new entry
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= ST_IDLE;
         idx_r <= 2'h0;
         fbase_r <= '0;
         pbase_r <= '0;
         pend_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         unique case (st_r)
            ST_IDLE, ST_REQ: begin
               if (trg_any) begin
                  st_r <= ST_REQ;
                  idx_r <= 2'h0;
                  fbase_r <= trg_addr;
                  bad_r <= 1'b0;
                  pend_r <= 1'b0;
               end else if (st_r == ST_REQ && mem_req_rdy) begin
                  st_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (trg_any) begin
                  pend_r <= 1'b1;
                  pbase_r <= trg_addr;
               end
               if (mem_rsp_v) begin
                  if (pend_r) begin
                     st_r <= ST_REQ;
                     idx_r <= 2'h0;
                     // Newest trigger wins; an older parked address is dropped
                     fbase_r <= trg_any ? trg_addr : pbase_r;
                     bad_r <= 1'b0;
                     pend_r <= 1'b0;
                  end else if (idx_r == LAST_IDX) begin
                     st_r <= trg_any ? ST_REQ : ST_IDLE;
                     idx_r <= 2'h0;
                     fbase_r <= trg_addr;
                     bad_r <= 1'b0;
                     pend_r <= 1'b0;
                  end else begin
                     st_r <= ST_REQ;
                     idx_r <= 2'(idx_r + 2'h1);
                     bad_r <= seq_bad;
                  end
               end
            end
         endcase
      end
   end

   // Staging buffer keeps the live entries intact until all pass
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stg_r <= '0;
      end else if (rsp_take) begin
         stg_r[idx_r] <= mem_rsp_data; // R23
      end
   end

   // Entry registers: virtualization load wins over a fetch commit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ent_r <= '0;
      end else if (virt_ld) begin
         ent_r <= virt_ent; // R10
      end else if (commit) begin
         ent_r <= {mem_rsp_data, stg_r[2], stg_r[1], stg_r[0]}; // R03 R23
      end
   end

   // Completion pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         done_r <= 1'b0;
         gp_r <= 1'b0;
      end else begin
         done_r <= commit;
         gp_r <= fault; // R16
      end
   end

   ////////////////////////////////////////////////////////////////
   // Translation lookup, entry registers only
   wire [1:0] sel = xl_lin[SEL_HI:SEL_LO]; // R21
   wire [63:0] ent_sel = ent_r[sel]; // R04 R22
   wire [PA_W-1:0] pa_mask = ~({PA_W{1'b1}} << MAX_PA); // R18
   // Bits 11:9 of the entry never reach the address
   wire [PA_W-1:0] dir_base = {ent_sel[PA_W-1:DIR_LO], 12'h000} & pa_mask; // R02 R14 R18

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
         ans_r <= '0;
      end else begin
         ack_r <= xl_req;
         if (xl_req) begin
            ans_r.dir_base <= dir_base;
            ans_r.write_through_attr <= ent_sel[PWT_BIT]; // R13
            ans_r.cache_disable_attr <= ent_sel[PCD_BIT]; // R13
            ans_r.page_fault <= ~ent_sel[P_BIT]; // R12 R21
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs
   assign ext_mode = mode_on;
   assign translation_table_base = base_r;
   assign ctl_out = ctl_r;
   assign busy = (st_r != ST_IDLE);
   assign load_done = done_r;
   assign gp_fault = gp_r;
   assign gp_err_code = gp_r ? GP_CODE : 16'h0000;
   assign xl_ack = ack_r;
   assign xl_ans = ans_r;

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_mode;
      @(posedge clk) disable iff (!arst_n)
      $past(mode_wr) |-> ext_mode == ($past(mode_wdata.pg) & $past(mode_wdata.pae) & ~lme);
   endproperty
   a_mode: assert property (p_mode) else $error("mode active wrong"); // R01

   property p_keep;
      @(posedge clk) disable iff (!arst_n)
      gp_fault && !$past(virt_ld) |-> $stable(ent_r) && !load_done;
   endproperty
   a_keep: assert property (p_keep) else $error("entries changed on fault"); // R16

   property p_code;
      @(posedge clk) disable iff (!arst_n)
      gp_fault |-> gp_err_code == 16'h0000;
   endproperty
   a_code: assert property (p_code) else $error("fault code not zero"); // R16

   property p_base;
      @(posedge clk) disable iff (!arst_n)
      base_wr && ext_mode && st_r != ST_WAIT |=>
         mem_req_v && mem_req.addr[31:5] == $past(base_wdata[31:5]) && mem_req.addr[4:0] == 5'h00;
   endproperty
   a_base: assert property (p_base) else $error("reload base wrong"); // R08

   property p_step;
      @(posedge clk) disable iff (!arst_n)
      rsp_take && !pend_r && !trg_any && idx_r != 2'h3 |=>
         mem_req_v && mem_req.addr[4:3] == 2'($past(idx_r) + 2'h1);
   endproperty
   a_step: assert property (p_step) else $error("entry offset wrong"); // R23

   property p_attr;
      @(posedge clk) disable iff (!arst_n)
      mem_req_v && !ctl_r.cd && !UC_FETCH |-> mem_req.attr == ATTR_WB;
   endproperty
   a_attr: assert property (p_attr) else $error("fetch not write-back"); // R11

   property p_pf;
      @(posedge clk) disable iff (!arst_n)
      xl_req |=> xl_ack && xl_ans.page_fault == !$past(ent_sel[0]);
   endproperty
   a_pf: assert property (p_pf) else $error("page fault flag wrong"); // R21

   property p_high;
      @(posedge clk) disable iff (!arst_n)
      xl_ack |-> (xl_ans.dir_base >> MAX_PA) == '0 && xl_ans.dir_base[11:0] == 12'h000;
   endproperty
   a_high: assert property (p_high) else $error("address high bits set"); // R18

endmodule : dir_pointer_entry_loader

/* File: src/dpe_pkg.sv */
package dpe_pkg;
   // Table geometry
   localparam int N_ENT = 4;
   localparam int ENT_W = 64;
   localparam int PA_W = 52;
   localparam int LIN_W = 32;
   localparam int BASE_LO = 5;
   localparam int BASE_HI = 31;
   localparam int OFS_LO = 3;
   localparam int DIR_LO = 12;
   localparam int SEL_LO = 30;
   localparam int SEL_HI = 31;
   // Entry fields
   localparam int P_BIT = 0;
   localparam int PWT_BIT = 3;
   localparam int PCD_BIT = 4;
   // Bits 2:1 and 8:5 must be zero
   localparam logic [63:0] RSV_LO_MASK = 64'h0000_0000_0000_01E6;
   localparam logic [15:0] GP_CODE = 16'h0000;
   localparam logic [1:0] LAST_IDX = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_WAIT = 3'b100
   } st_t;

   typedef enum logic {
      ATTR_UC = 1'b0,
      ATTR_WB = 1'b1
   } mem_attr_t;

   typedef struct packed {
      logic pg;   // paging_enable
      logic pae;  // phys_addr_extension
      logic cd;   // cache_disable_ctl
      logic nw;   // no_writethrough_ctl
      logic pge;  // global_page_enable
      logic pse;  // large_page_enable
   } mode_ctl_t;

   typedef struct packed {
      logic [PA_W-1:0] addr;
      mem_attr_t attr;
   } mem_req_t;

   typedef struct packed {
      logic [PA_W-1:0] dir_base;
      logic write_through_attr;
      logic cache_disable_attr;
      logic page_fault;
   } xl_ans_t;
endpackage : dpe_pkg

/* File: bench/mem_model.sv */
`timescale 1ns/10ps
module mem_model
   import dpe_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic arst_n, // async reset
   input wire logic slow, // stretch both waits
   input wire logic [N_ENT-1:0][63:0] tbl, // table contents
   input wire logic mem_req_v, // read request
   input wire mem_req_t mem_req, // address, attr
   output logic mem_req_rdy, // request taken
   output logic mem_rsp_v, // data valid
   output logic [63:0] mem_rsp_data, // read data
   output logic [PA_W-1:0] last_addr, // last taken address
   output mem_attr_t last_attr, // last taken attr
   output int n_rd // reads taken
);
   logic [2:0] cnt_r;
   logic pend_r;
   logic [1:0] idx_r;
   ////////////////////////////////////////////////////////////
   // One read at a time; data inverts once released so stale values never pass
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {mem_req_rdy, mem_rsp_v, pend_r, cnt_r, idx_r} <= '0;
         mem_rsp_data <= '0;
         last_addr <= '0;
         last_attr <= ATTR_UC;
         n_rd <= 0;
      end else begin
         mem_req_rdy <= 1'b0;
         mem_rsp_v <= 1'b0;
         if (mem_rsp_v) mem_rsp_data <= ~mem_rsp_data;
         if (mem_req_v && mem_req_rdy) begin
            pend_r <= 1'b1;
            cnt_r <= slow ? 3'h3 : 3'h0;
            idx_r <= mem_req.addr[4:3];
            last_addr <= mem_req.addr;
            last_attr <= mem_req.attr;
            n_rd <= n_rd + 1;
         end else if (pend_r) begin
            cnt_r <= cnt_r - 3'h1;
            if (cnt_r == 3'h0) begin
               mem_rsp_v <= 1'b1;
               mem_rsp_data <= tbl[idx_r];
               pend_r <= 1'b0;
               cnt_r <= 3'h0;
            end
         end else if (mem_req_v) begin
            cnt_r <= cnt_r + 3'h1;
            if (!slow || cnt_r == 3'h2) begin
               mem_req_rdy <= 1'b1;
               cnt_r <= 3'h0;
            end
         end
      end
   end
endmodule : mem_model

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import dpe_pkg::*;
   logic clk = 0, arst_n = 0, lme = 0, mode_wr = 0, base_wr = 0, task_sw = 0;
   logic virt_ld = 0, xl_req = 0, slow = 0;
   mode_ctl_t mode_wdata = '0;
   logic [63:0] base_wdata = '0;
   logic [N_ENT-1:0][63:0] virt_ent = '0, tbl = '0;
   logic [LIN_W-1:0] xl_lin = '0;
   logic mem_req_v, mem_req_rdy, mem_rsp_v, ext_mode, busy, load_done, gp_fault, xl_ack;
   mem_req_t mem_req;
   logic [63:0] mem_rsp_data, translation_table_base;
   mode_ctl_t ctl_out;
   logic [15:0] gp_err_code;
   xl_ans_t xl_ans;
   logic [PA_W-1:0] last_addr;
   mem_attr_t last_attr;
   int n_rd, n_errors = 0, check_count = 0;
   // Narrow physical width so the upper reserved bits get exercised
   dir_pointer_entry_loader #(.MAX_PA(40)) uut (.*);
   mem_model mem (.*);
   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr_mode(input mode_ctl_t v);
      mode_wdata = v;
      mode_wr = 1;
      tick(1);
      mode_wr = 0;
   endtask : wr_mode
   task automatic wr_base(input logic [63:0] v, input logic ts);
      base_wdata = v;
      if (ts) task_sw = 1;
      else base_wr = 1;
      tick(1);
      {base_wr, task_sw} = 2'h0;
   endtask : wr_base
   // Bounded wait for the commit or the fault pulse, then judge the fetch
   task automatic expect_load(input int n0, input logic [51:0] a, input mem_attr_t t, input logic gp);
      logic d, g;
      {d, g} = 2'h0;
      for (int i = 0; i < 300 && !d && !g; i++) begin
         d = load_done;
         g = gp_fault;
         if (g) check(gp_err_code === GP_CODE, "fault code");
         if (!(d | g)) tick(1);
      end
      check(g === gp && d === !gp, "commit or fault");
      check(n_rd - n0 === 4 && last_addr === a, "read count or address");
      check(last_attr === t, "fetch attribute");
   endtask : expect_load
   task automatic look(input logic [1:0] s, input logic [51:0] b, input logic [2:0] f);
      xl_lin = {s, 30'h2BCD_EF12};
      xl_req = 1;
      tick(1);
      xl_req = 0;
      check(xl_ack === 1'b1, "lookup ack");
      check({xl_ans.write_through_attr, xl_ans.cache_disable_attr, xl_ans.page_fault} === f, "lookup flags");
      if (!f[0]) check(xl_ans.dir_base === b, "lookup base");
      tick(1);
      check(xl_ack === 1'b0, "ack lasts one cycle");
   endtask : look
   task automatic end_sim();
      $display("errors %0d, checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic s_enable();
      wr_base(64'hFFFF_FFFF_8000_101F, 0);
      tick(3);
      check(n_rd === 0 && ext_mode === 1'b0, "idle while mode off");
      check(translation_table_base === 64'hFFFF_FFFF_8000_101F, "base held");
      wr_mode(6'h30);
      check(ext_mode === 1'b1 && ctl_out === 6'h30, "mode on");
      expect_load(0, 52'h8000_1018, ATTR_WB, 0);
      look(0, 52'h1234_5000, 3'h6);
      look(1, 52'hFF_FFFF_F000, 3'h0);
      look(2, 52'h0, 3'h1);
      look(3, 52'h0, 3'h1);
   endtask : s_enable
   // Each pattern sets one reserved bit beside the valid flag
   task automatic s_fault();
      logic [63:0] pat [5] = '{64'h3, 64'h5, 64'h21, 64'h101_0000_0001, 64'h8000_0000_0000_0001};
      slow = 1;
      foreach (pat[i]) begin
         tbl[2] = pat[i];
         wr_base(64'h2000 + 64'(i) * 64'h20, 0);
         expect_load(n_rd, 52'h2018 + 52'(i) * 52'h20, ATTR_WB, 1);
      end
      look(2, 52'h0, 3'h1);
      look(0, 52'h1234_5000, 3'h6);
      tbl[2] = '0;
      wr_base(64'h2080, 1);
      tick(6);
      check(busy === 1'b0, "no reload on same base");
      wr_base(64'h6000, 1);
      expect_load(n_rd, 52'h6018, ATTR_WB, 0);
      slow = 0;
   endtask : s_fault
   task automatic s_mode();
      wr_mode(6'h38);
      expect_load(n_rd, 52'h6018, ATTR_UC, 0);
      wr_mode(6'h38);
      tick(3);
      check(busy === 1'b0, "no reload without change");
      wr_mode(6'h37);
      expect_load(n_rd, 52'h6018, ATTR_WB, 0);
      lme = 1;
      tick(1);
      check(ext_mode === 1'b0, "long mode blocks");
      wr_base(64'h7000, 0);
      tick(3);
      check(busy === 1'b0, "no reload outside mode");
      lme = 0;
   endtask : s_mode
   task automatic s_virt();
      virt_ent[1] = 64'h000F_F000_0000_1009;
      virt_ld = 1;
      tick(1);
      virt_ld = 0;
      look(1, 52'h1000, 3'h4);
   endtask : s_virt
   ////////////////////////////////////////////////////////////
   initial begin
      tbl[0] = 64'h1234_5E19;
      tbl[1] = 64'hFF_FFFF_F001;
      tbl[3] = 64'hFFFF_0000_0000_01E6;
      repeat (10) @(posedge clk);
      #1;
      check(translation_table_base === 64'h0 && busy === 1'b0, "reset state");
      arst_n = 1;
      tick(1);
      s_enable();
      s_fault();
      s_mode();
      s_virt();
      end_sim();
   end
   // Watchdog well beyond the expected run
   initial begin
      #40000;
      n_errors++;
      end_sim();
   end
endmodule : tb_top
